// file: core/mtbct_core.sv
// Cycle sequencer for block loads, block stores and relative branches.
// Assumes a memory system taking one access per cycle and a register file beside it.
// Summary of operation
// - Block load fills each listed register from successive addresses, (n+1)S plus 1N.
// - Block store writes each listed register to successive addresses, (n+1)S plus 2N.
// - Plain branch sets PC to PC plus offset in 2S plus 1N.
// - Branch with save copies PC into register 14, then adds offset.
// - Branch with save takes the same 2S plus 1N as a plain branch.
// - Every access is marked sequential or non-sequential; timing counts both kinds.
// - The count n equals the number of bits set in the list.
`timescale 1ns/10ps
module mtbct_core (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  input  wire logic                       i_start,
  input  wire mtbct_pkg::mtbct_cmd_s      i_cmd,
  output logic                            o_ready,
  output mtbct_pkg::mtbct_mem_s           o_mem,
  output logic                            o_rf_we,
  output logic [mtbct_pkg::REG_IDX_W-1:0] o_rf_idx,
  output logic [mtbct_pkg::DATA_W-1:0]    o_rf_data,
  output logic [mtbct_pkg::DATA_W-1:0]    o_pc,
  output logic [7:0]                      o_s_cycles,
  output logic [7:0]                      o_n_cycles,
  output logic                            o_done
);
  import mtbct_pkg::*;

  mtbct_state_s st_r;
  mtbct_state_s st_nxt;

  // Population count of a register list
  function automatic logic [4:0] list_count(input logic [LIST_W-1:0] l);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < LIST_W; i++) begin
      c = c + {4'h0, l[i]};
    end
    return c;
  endfunction

  // Index of the lowest set bit
  function automatic logic [REG_IDX_W-1:0] low_idx(input logic [LIST_W-1:0] l);
    logic [REG_IDX_W-1:0] r;
    r = '0;
    for (int i = LIST_W-1; i >= 0; i--) begin
      if (l[i]) begin
        r = REG_IDX_W'(i);
      end
    end
    return r;
  endfunction

  logic [DATA_W-1:0] offs_ext;
  assign offs_ext = {{(DATA_W-OFFS_W){st_r.offset[OFFS_W-1]}}, st_r.offset};

  always_comb begin
    st_nxt          = st_r;
    st_nxt.mem      = '0;
    st_nxt.rf_we    = 1'b0;
    st_nxt.done     = 1'b0;
    unique case (st_r.state)
      MTBCT_ST_IDLE: begin
        if (i_start) begin
          st_nxt.op       = i_cmd.op;
          st_nxt.list     = i_cmd.reg_list;
          st_nxt.addr     = i_cmd.base_addr;
          st_nxt.offset   = i_cmd.offset;
          st_nxt.s_cnt    = 8'h00;
          st_nxt.n_cnt    = 8'h00;
          st_nxt.state    = MTBCT_ST_NSEQ;
          unique case (i_cmd.op)
            MTBCT_OP_LOAD: begin
              st_nxt.n_count   = list_count(i_cmd.reg_list);
              st_nxt.seq_left  = list_count(i_cmd.reg_list) + SEQ_EXTRA;
              st_nxt.nseq_left = LOAD_NSEQ;
            end
            MTBCT_OP_STORE: begin
              st_nxt.n_count   = list_count(i_cmd.reg_list);
              st_nxt.seq_left  = list_count(i_cmd.reg_list) + SEQ_EXTRA;
              st_nxt.nseq_left = STORE_NSEQ;
            end
            default: begin
              st_nxt.n_count   = 5'h00;
              st_nxt.seq_left  = BR_SEQ;
              st_nxt.nseq_left = BR_NSEQ;
            end
          endcase
        end
      end
      MTBCT_ST_NSEQ: begin
        // Non-sequential cycle opens each sequence; store adds its own at the end
        st_nxt.mem.valid  = 1'b1;
        st_nxt.mem.nonseq = 1'b1;
        st_nxt.n_cnt      = st_r.n_cnt + 8'h01;
        st_nxt.nseq_left  = st_r.nseq_left - 2'h1;
        if (st_r.op == MTBCT_OP_BRANCH || st_r.op == MTBCT_OP_BSAVE) begin
          st_nxt.mem.addr = st_r.pc + offs_ext;
          st_nxt.pc       = st_r.pc + offs_ext;
          if (st_r.op == MTBCT_OP_BSAVE) begin
            st_nxt.rf_we   = 1'b1;
            st_nxt.rf_idx  = RET_REG;
            st_nxt.rf_data = st_r.pc;
          end
        end else begin
          st_nxt.mem.addr = st_r.addr;
        end
        if (st_r.seq_left != 5'h00) begin
          st_nxt.state = MTBCT_ST_SEQ;
        end else begin
          st_nxt.state = MTBCT_ST_IDLE;
          st_nxt.done  = 1'b1;
        end
      end
      MTBCT_ST_SEQ: begin
        st_nxt.mem.valid  = 1'b1;
        st_nxt.mem.nonseq = 1'b0;
        st_nxt.s_cnt      = st_r.s_cnt + 8'h01;
        st_nxt.seq_left   = st_r.seq_left - 5'h01;
        st_nxt.mem.addr   = st_r.addr;
        if (st_r.list != '0 && (st_r.op == MTBCT_OP_LOAD || st_r.op == MTBCT_OP_STORE)) begin
          st_nxt.mem.reg_idx = low_idx(st_r.list);
          st_nxt.mem.write   = (st_r.op == MTBCT_OP_STORE);
          st_nxt.rf_we       = (st_r.op == MTBCT_OP_LOAD);
          st_nxt.rf_idx      = low_idx(st_r.list);
          st_nxt.rf_data     = st_r.addr;
          st_nxt.list        = st_r.list & (st_r.list - LIST_W'(1));
          st_nxt.addr        = st_r.addr + 32'h0000_0004;
        end
        if (st_r.seq_left == 5'h01) begin
          if (st_r.nseq_left != 2'h0) begin
            st_nxt.state = MTBCT_ST_NSEQ;
            st_nxt.seq_left = 5'h00;
          end else begin
            st_nxt.state = MTBCT_ST_IDLE;
            st_nxt.done  = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.state = MTBCT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r       <= '0;
      st_r.pc    <= PC_RST;
      st_r.state <= MTBCT_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ready    = (st_r.state == MTBCT_ST_IDLE);
  assign o_mem      = st_r.mem;
  assign o_rf_we    = st_r.rf_we;
  assign o_rf_idx   = st_r.rf_idx;
  assign o_rf_data  = st_r.rf_data;
  assign o_pc       = st_r.pc;
  assign o_s_cycles = st_r.s_cnt;
  assign o_n_cycles = st_r.n_cnt;
  assign o_done     = st_r.done;

  AST_LOAD_TIMING: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_LOAD) |->
      (o_s_cycles == {3'h0, st_r.n_count} + 8'h01 && o_n_cycles == 8'h01))
    else $error("Block load cycle count wrong");
  AST_STORE_TIMING: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_STORE) |->
      (o_s_cycles == {3'h0, st_r.n_count} + 8'h01 && o_n_cycles == 8'h02))
    else $error("Block store cycle count wrong");
  AST_BRANCH_TIMING: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_BRANCH) |-> (o_s_cycles == 8'h02 && o_n_cycles == 8'h01))
    else $error("Branch cycle count wrong");
  AST_BSAVE_TIMING: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_BSAVE) |-> (o_s_cycles == 8'h02 && o_n_cycles == 8'h01))
    else $error("Branch with save cycle count wrong");
  AST_BRANCH_PC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r.state == MTBCT_ST_NSEQ && st_r.op[1]) |=> (o_pc == $past(st_r.pc) + $past(offs_ext)))
    else $error("Branch target wrong");
  AST_BSAVE_LINK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r.state == MTBCT_ST_NSEQ && st_r.op == MTBCT_OP_BSAVE) |=>
      (o_rf_we && o_rf_idx == 4'hE && o_rf_data == $past(st_r.pc)))
    else $error("Return address not saved");
  AST_NONSEQ_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_start && o_ready) |=> ##1 (o_mem.valid && o_mem.nonseq))
    else $error("Sequence does not open with non-sequential access");
  AST_LIST_COUNT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_start && o_ready && !i_cmd.op[1]) |=> (st_r.n_count == $countones($past(i_cmd.reg_list))))
    else $error("Transfer count differs from list size");
  AST_LOAD_WRITES: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_LOAD) |-> (st_r.list == '0))
    else $error("Block load left registers unfilled");

  // Access classification
  AST_BUSY_ACCESS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r.state != MTBCT_ST_IDLE) |=> o_mem.valid)
    else $error("Busy cycle without a memory access");
  AST_OPEN_NSEQ_COUNT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_mem.valid && o_mem.nonseq && o_s_cycles == 8'h00) |-> (o_n_cycles == 8'h01))
    else $error("Opening non-sequential access miscounted");

  // Block transfer ordering
  AST_LOAD_ENDS_SEQ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_LOAD) |-> (o_mem.valid && !o_mem.nonseq))
    else $error("Block load does not end on a sequential access");
  AST_STORE_ENDS_NSEQ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_done && st_r.op == MTBCT_OP_STORE) |-> (o_mem.valid && o_mem.nonseq))
    else $error("Block store does not end on a non-sequential access");
  AST_XFER_STEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r.state == MTBCT_ST_SEQ && st_r.list != '0 && !st_r.op[1]) |=>
      (o_mem.addr == $past(st_r.addr) && st_r.addr == $past(st_r.addr) + 32'h0000_0004))
    else $error("Transfer address does not step by one word");
  AST_LIST_DRAINS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r.state == MTBCT_ST_SEQ && st_r.list != '0 && !st_r.op[1]) |=>
      ($countones(st_r.list) == $countones($past(st_r.list)) - 1))
    else $error("Transfer did not retire exactly one listed register");
  AST_WRITE_STORE_ONLY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem.write |-> (st_r.op == MTBCT_OP_STORE && !o_mem.nonseq))
    else $error("Write access outside a block store transfer");
  AST_FILL_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_rf_we |-> (st_r.op == MTBCT_OP_LOAD || st_r.op == MTBCT_OP_BSAVE))
    else $error("Register write outside a load or a saving branch");

  // Refused request leaves the running instruction alone
  AST_REFUSE_BUSY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_start && !o_ready) |=>
      (st_r.op == $past(st_r.op) && st_r.n_count == $past(st_r.n_count)))
    else $error("Request taken while busy");
endmodule

// file: core/mtbct_pkg.sv
// Package for the block transfer and branch cycle sequencer.
// Assumes one system clock; shared by the core module, the memory partner model and the bench.
package mtbct_pkg;
  localparam int          DATA_W     = 32;
  localparam int          LIST_W     = 16;
  localparam int          REG_IDX_W  = 4;
  localparam int          OFFS_W     = 24;
  localparam logic [3:0]  RET_REG    = 4'hE;
  localparam logic [31:0] PC_RST     = 32'h0000_0000;
  localparam logic [4:0]  SEQ_EXTRA  = 5'h01;
  localparam logic [4:0]  BR_SEQ     = 5'h02;
  localparam logic [1:0]  LOAD_NSEQ  = 2'h1;
  localparam logic [1:0]  STORE_NSEQ = 2'h2;
  localparam logic [1:0]  BR_NSEQ    = 2'h1;

  typedef enum logic [1:0] {
    MTBCT_OP_LOAD   = 2'b00,
    MTBCT_OP_STORE  = 2'b01,
    MTBCT_OP_BRANCH = 2'b10,
    MTBCT_OP_BSAVE  = 2'b11
  } mtbct_op_e;

  typedef enum logic [1:0] {
    MTBCT_ST_IDLE = 2'b00,
    MTBCT_ST_NSEQ = 2'b01,
    MTBCT_ST_SEQ  = 2'b10
  } mtbct_state_e;

  typedef struct packed {
    mtbct_op_e          op;
    logic [LIST_W-1:0]  reg_list;
    logic [DATA_W-1:0]  base_addr;
    logic [OFFS_W-1:0]  offset;
  } mtbct_cmd_s;

  typedef struct packed {
    logic               valid;
    logic               nonseq;
    logic               write;
    logic [DATA_W-1:0]  addr;
    logic [REG_IDX_W-1:0] reg_idx;
  } mtbct_mem_s;

  typedef struct packed {
    mtbct_state_e       state;
    mtbct_op_e          op;
    logic [LIST_W-1:0]  list;
    logic [DATA_W-1:0]  addr;
    logic [DATA_W-1:0]  pc;
    logic [OFFS_W-1:0]  offset;
    logic [4:0]         seq_left;
    logic [1:0]         nseq_left;
    logic [4:0]         n_count;
    mtbct_mem_s         mem;
    logic               rf_we;
    logic [REG_IDX_W-1:0] rf_idx;
    logic [DATA_W-1:0]  rf_data;
    logic [7:0]         s_cnt;
    logic [7:0]         n_cnt;
    logic               done;
  } mtbct_state_s;
endpackage

// file: bench/mtbct_mem_model.sv
// Memory partner: serves one access per cycle and counts each kind it sees.
// Assumes the sequencer drives one registered access record per cycle.
`timescale 1ns/10ps
module mtbct_mem_model (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire mtbct_pkg::mtbct_mem_s i_mem,
  output logic [31:0]                o_s_total,
  output logic [31:0]                o_n_total
);
  import mtbct_pkg::*;
  // Served accesses, split by cycle type
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_s_total <= 32'h0;
      o_n_total <= 32'h0;
    end else if (i_mem.valid) begin
      if (i_mem.nonseq) o_n_total <= o_n_total + 32'h1;
      else o_s_total <= o_s_total + 32'h1;
    end
  end
endmodule

// file: bench/test_multi_transfer_branch_cycle_timing.sv
// Self-checking bench for the block transfer and branch cycle sequencer.
// Assumes the core and its package, and the memory partner model.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_multi_transfer_branch_cycle_timing;
  import mtbct_pkg::*;
  logic i_clk_sys = 0, i_rst = 1, i_start = 0;
  mtbct_cmd_s           i_cmd = '0;
  logic                 o_ready, o_rf_we, o_done;
  mtbct_mem_s           o_mem;
  logic [REG_IDX_W-1:0] o_rf_idx;
  logic [DATA_W-1:0]    o_rf_data, o_pc;
  logic [7:0]           o_s_cycles, o_n_cycles;
  logic [31:0]          s_tot, n_tot;
  logic [REG_IDX_W-1:0] rq[$], wq[$];
  logic [DATA_W-1:0]    dq[$], aq[$], wa[$];
  int fail_count = 0, checks_done = 0, cyc = 0, seed = 26;

  always #2 i_clk_sys = ~i_clk_sys;

  mtbct_core dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(i_start), .i_cmd(i_cmd),
    .o_ready(o_ready), .o_mem(o_mem), .o_rf_we(o_rf_we), .o_rf_idx(o_rf_idx),
    .o_rf_data(o_rf_data), .o_pc(o_pc), .o_s_cycles(o_s_cycles),
    .o_n_cycles(o_n_cycles), .o_done(o_done));
  mtbct_mem_model mem (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mem(o_mem),
    .o_s_total(s_tot), .o_n_total(n_tot));

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Register writes, stored registers and the cycle ceiling
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_rf_we === 1'b1) begin
      rq.push_back(o_rf_idx);
      dq.push_back(o_rf_data);
    end
    if (o_mem.valid === 1'b1 && o_mem.nonseq === 1'b1)
      aq.push_back(o_mem.addr);
    if (o_mem.valid === 1'b1 && o_mem.nonseq === 1'b0 && o_mem.write === 1'b1) begin
      wq.push_back(o_mem.reg_idx);
      wa.push_back(o_mem.addr);
    end
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic run(input mtbct_op_e op, input logic [15:0] lst, input logic [23:0] off);
    int n, k, w, ew;
    logic [31:0] s0, n0, pc0, es, en, base, ea;
    n = $countones(lst);
    pc0 = o_pc;
    s0 = s_tot;
    n0 = n_tot;
    rq.delete();
    dq.delete();
    wq.delete();
    aq.delete();
    wa.delete();
    base = $random(seed) & 32'h0000_FFFC;
    ea = op[1] ? pc0 + {{8{off[23]}}, off} : base;
    es = (op == MTBCT_OP_LOAD || op == MTBCT_OP_STORE) ? n + 1 : 2;
    en = (op == MTBCT_OP_STORE) ? 2 : 1;
    ew = (op == MTBCT_OP_LOAD) ? n : (op == MTBCT_OP_BSAVE) ? 1 : 0;
    `CHK("ready", 1'b1, o_ready)
    @(posedge i_clk_sys);
    i_start <= 1'b1;
    i_cmd <= '{op, lst, base, off};
    @(posedge i_clk_sys);
    i_start <= 1'b0;
    @(posedge i_clk_sys);
    i_start <= 1'b1;
    i_cmd.op <= MTBCT_OP_BRANCH;
    @(posedge i_clk_sys);
    i_start <= 1'b0;
    w = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      w++;
    end while (o_done !== 1'b1 && w < 100);
    `CHK("done", 1'b1, o_done)
    `CHK("s cycles", es[7:0], o_s_cycles)
    `CHK("n cycles", en[7:0], o_n_cycles)
    // The partner counts the closing access one edge after it is issued
    @(posedge i_clk_sys);
    #1;
    `CHK("s served", es, s_tot - s0)
    `CHK("n served", en, n_tot - n0)
    `CHK("first n addr", ea, aq[0])
    k = 0;
    if (op == MTBCT_OP_LOAD || op == MTBCT_OP_STORE) begin
      for (int i = 0; i < LIST_W; i++) if (lst[i]) begin
        if (op == MTBCT_OP_LOAD) `CHK("load idx", REG_IDX_W'(i), rq[k])
        else `CHK("store idx", REG_IDX_W'(i), wq[k])
        if (op == MTBCT_OP_LOAD) `CHK("load addr", base + 32'(4 * k), dq[k])
        else `CHK("store addr", base + 32'(4 * k), wa[k])
        k++;
      end
      `CHK("pc kept", pc0, o_pc)
    end else
      `CHK("pc", pc0 + {{8{off[23]}}, off}, o_pc)
    if (op == MTBCT_OP_STORE) `CHK("store end addr", base + 32'(4 * n), aq[1])
    `CHK("load writes", ew, rq.size())
    `CHK("store writes", (op == MTBCT_OP_STORE) ? n : 0, wq.size())
    if (op == MTBCT_OP_BSAVE) begin
      `CHK("save count", 1, rq.size())
      `CHK("save idx", RET_REG, rq[0])
      `CHK("save data", pc0, dq[0])
    end
  endtask

  initial begin
    logic [15:0] lst;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int t = 0; t < 16; t++) begin
      lst = (t < 4) ? 16'hFFFF : (t < 8) ? 16'(16'h0001 << ((t - 4) * 5)) : 16'($random(seed));
      if (lst == 16'h0000) lst = 16'h8000;
      run(mtbct_op_e'(t % 4), lst, 24'($random(seed)));
      $display("Test %0d done", t);
    end
    complete_run();
  end
endmodule
